// ### drive_prot_pkg.sv
// Purpose: shared constants for the drive protection monitor
// Assumes: 50 MHz mclk, AXI4-Lite register access
// Notes: times are in 100 ms ticks unless stated
package drive_prot_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOSS_TIME_OFS = 8'h04;
  localparam logic [7:0] OUT_FUNC_OFS = 8'h08;
  localparam logic [7:0] BRAKE_DUTY_OFS = 8'h0C;
  localparam logic [7:0] BRAKE_CYCLE_OFS = 8'h10;
  localparam logic [7:0] VOLT_TH_OFS = 8'h14;
  localparam logic [7:0] CUR_TH_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CRIT_LSB = 0;
  localparam int ACTION_LSB = 2;
  localparam int BRAKE_EN_BIT = 4;
  localparam int CHARGE_EN_BIT = 5;
  localparam int SUM_MODE_BIT = 6;
  localparam int OUT2_LSB = 8;
  localparam int SECOND_TH_LSB = 16;
  localparam logic [1:0] CRIT_OFF = 2'h0;
  localparam logic [1:0] CRIT_HALF = 2'h1;
  localparam logic [1:0] CRIT_FULL = 2'h2;
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_BLOCK = 2'h1;
  localparam logic [1:0] ACT_DECEL = 2'h2;
  localparam logic [4:0] FUNC_LOSS = 5'h0B;
  localparam logic [4:0] FUNC_RST = 5'h11;
  localparam logic [10:0] LOSS_TIME_RST = 11'h00A;
  localparam logic [10:0] LOSS_TIME_MIN = 11'h001;
  localparam logic [10:0] LOSS_TIME_MAX = 11'h4B0;
  localparam logic [4:0] DUTY_RST = 5'h0A;
  localparam logic [4:0] DUTY_MAX = 5'h1E;
  localparam logic [15:0] CYCLE_RST = 16'h0064;
  localparam logic [11:0] TH_RST = 12'h100;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int BRAKE_CONT_MS = 15_000;
  localparam logic [7:0] BRAKE_CONT_TICKS = 8'(BRAKE_CONT_MS / TICK_MS);
endpackage : drive_prot_pkg

// ### loss_timer.sv
// Purpose: qualifies a loss candidate over the detection time
// Assumes: tick is a one-cycle 100 ms enable
// Notes: confirmed stays high while the candidate persists
`timescale 1ns/1ns
module loss_timer
  import drive_prot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic tick,
  input wire logic candidate,
  input wire logic [10:0] limit,
  // result
  output logic confirmed
);
  logic [10:0] count;

  // tick counter; restarts from zero on a dropped candidate
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 11'h000;
    end else if (!candidate) begin
      count <= 11'h000;
    end else if (tick && count < limit) begin
      count <= count + 11'h001;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      confirmed <= 1'b0;
    end else begin
      confirmed <= candidate && (count >= limit);
    end
  end
endmodule : loss_timer

// ### brake_limiter.sv
// Purpose: duty and continuous-time limit for the braking resistor
// Assumes: tick is a one-cycle 100 ms enable
// Notes: budget is rounded down to whole ticks
`timescale 1ns/1ns
module brake_limiter
  import drive_prot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic tick,
  input wire logic brake_request,
  input wire logic limit_enable,
  input wire logic [4:0] duty_percent,
  input wire logic [15:0] cycle_ticks,
  // status
  output logic brake_drive,
  output logic budget_spent,
  output logic cont_cutoff
);
  logic [15:0] cycle_pos;
  logic [15:0] used;
  logic [7:0] cont;
  logic [20:0] product;
  logic [15:0] budget;

  // budget is duty share of cycle
  assign product = cycle_ticks * duty_percent;
  assign budget = 16'(product / 21'd100);

  // operating cycle position and energised ticks in it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cycle_pos <= 16'h0000;
      used <= 16'h0000;
    end else if (tick) begin
      if (cycle_pos + 16'h0001 >= cycle_ticks) begin
        cycle_pos <= 16'h0000;
        used <= 16'h0000;
      end else begin
        cycle_pos <= cycle_pos + 16'h0001;
        if (brake_drive) begin
          used <= used + 16'h0001;
        end
      end
    end
  end

  // continuous braking length, reset when the request drops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cont <= 8'h00;
    end else if (!brake_request) begin
      cont <= 8'h00;
    end else if (tick && cont < BRAKE_CONT_TICKS) begin
      cont <= cont + 8'h01;
    end
  end

  // drive decision, registered so the pin never glitches
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      brake_drive <= 1'b0;
      budget_spent <= 1'b0;
      cont_cutoff <= 1'b0;
    end else begin
      budget_spent <= used >= budget;
      cont_cutoff <= cont >= BRAKE_CONT_TICKS;
      brake_drive <= brake_request && !(cont >= BRAKE_CONT_TICKS)
                     && (!limit_enable || used < budget);
    end
  end
endmodule : brake_limiter

// ### drive_protection_monitor.sv
// Purpose: speed command loss, braking duty and charge trip protection
// Assumes: analog inputs are sampled words synchronous to mclk
// Notes: registers sit behind an AXI4-Lite slave
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module drive_protection_monitor
  import drive_prot_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog command inputs
  input wire logic [11:0] voltage_command_input,
  input wire logic [11:0] second_voltage_input,
  input wire logic [11:0] current_command_input,
  // drive state
  input wire logic brake_request,
  input wire logic powerup_phase,
  input wire logic power_unstable,
  input wire logic charge_circuit_fail,
  // reactions
  output logic hold_frequency,
  output logic output_block,
  output logic decel_stop,
  output logic relay_contact_output,
  output logic output2,
  output logic dynamic_braking,
  output logic charge_circuit_trip,
  output logic irq
);
  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [1:0] analog_loss_criterion;
  logic [1:0] loss_action_select;
  logic brake_duty_limit_enable;
  logic charge_trip_enable;
  logic sum_mode;
  logic [10:0] loss_detect_time;
  logic [4:0] relay_function_select;
  logic [4:0] output2_function_select;
  logic [4:0] brake_duty_percent;
  logic [15:0] brake_cycle_ticks;
  logic [11:0] voltage_input_threshold;
  logic [11:0] second_voltage_threshold;
  logic [11:0] current_input_threshold;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  // bus state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  // internal
  logic [22:0] div_count;
  logic tick;
  logic candidate;
  logic loss_active;
  logic loss_active_d;
  logic brake_drive;
  logic budget_spent;
  logic cont_cutoff;
  logic cont_cutoff_d;
  logic [2:0] events;
  logic [31:0] rd_word;
  logic rd_ok;

  function automatic logic below(input logic [11:0] x, input logic [11:0] th,
                                 input logic [1:0] crit);
    case (crit)
      CRIT_HALF: below = x < {1'b0, th[11:1]};
      CRIT_FULL: below = x < th;
      default: below = 1'b0;
    endcase
  endfunction : below

  // ----------------------------------------
  // 100 ms tick divider
  // ----------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_count <= 23'h000000;
      tick <= 1'b0;
    end else if (div_count >= 23'(TICK_LEN - 1)) begin
      div_count <= 23'h000000;
      tick <= 1'b1;
    end else begin
      div_count <= div_count + 23'h000001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // speed command loss
  // ----------------------------------------
  // either summed input may fail
  always_comb begin
    if (sum_mode) begin
      candidate = below(second_voltage_input, second_voltage_threshold, analog_loss_criterion)
                  || below(current_command_input, current_input_threshold, analog_loss_criterion);
    end else begin
      candidate = below(voltage_command_input, voltage_input_threshold, analog_loss_criterion);
    end
  end

  loss_timer u_loss (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .candidate(candidate),
    .limit(loss_detect_time),
    .confirmed(loss_active)
  );

  // reaction outputs; the trip also forces the output block
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_frequency <= 1'b0;
      output_block <= 1'b0;
      decel_stop <= 1'b0;
    end else begin
      hold_frequency <= loss_active && loss_action_select == ACT_HOLD;
      decel_stop <= loss_active && loss_action_select == ACT_DECEL;
      output_block <= (loss_active && loss_action_select == ACT_BLOCK) || charge_circuit_trip;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      relay_contact_output <= 1'b0;
      output2 <= 1'b0;
    end else begin
      relay_contact_output <= loss_active && relay_function_select == FUNC_LOSS;
      output2 <= loss_active && output2_function_select == FUNC_LOSS;
    end
  end

  // ----------------------------------------
  // braking and charge trip
  // ----------------------------------------
  brake_limiter u_brake (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .brake_request(brake_request && !charge_circuit_trip),
    .limit_enable(brake_duty_limit_enable),
    .duty_percent(brake_duty_percent),
    .cycle_ticks(brake_cycle_ticks),
    .brake_drive(brake_drive),
    .budget_spent(budget_spent),
    .cont_cutoff(cont_cutoff)
  );

  // output flop for the resistor drive
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dynamic_braking <= 1'b0;
    end else begin
      dynamic_braking <= brake_drive;
    end
  end

  // latched until reset, since running on a failed charge path risks damage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_circuit_trip <= 1'b0;
    end else if (charge_trip_enable && powerup_phase && (power_unstable || charge_circuit_fail)) begin
      charge_circuit_trip <= 1'b1;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      loss_active_d <= 1'b0;
      cont_cutoff_d <= 1'b0;
    end else begin
      loss_active_d <= loss_active;
      cont_cutoff_d <= cont_cutoff;
    end
  end

  assign events = {charge_circuit_trip, cont_cutoff && !cont_cutoff_d, loss_active && !loss_active_d};

  // write one clears, but a same-cycle event wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= 3'h0;
    end else if (do_write && aw_addr == IRQ_STAT_OFS && w_strb[0]) begin
      irq_status <= (irq_status & ~w_data[2:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= IRQ_MASK_OFS && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready drops while a word is held, so each channel moves one item per write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) || do_write;
      s_axi_wready <= !(w_held || (s_axi_wvalid && s_axi_wready)) || do_write;
    end
  end

  // settings write, out-of-range values are clamped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_loss_criterion <= CRIT_OFF;
      loss_action_select <= ACT_HOLD;
      brake_duty_limit_enable <= 1'b1;
      charge_trip_enable <= 1'b1;
      sum_mode <= 1'b0;
      loss_detect_time <= LOSS_TIME_RST;
      relay_function_select <= FUNC_RST;
      output2_function_select <= FUNC_RST;
      brake_duty_percent <= DUTY_RST;
      brake_cycle_ticks <= CYCLE_RST;
      voltage_input_threshold <= TH_RST;
      second_voltage_threshold <= TH_RST;
      current_input_threshold <= TH_RST;
      irq_mask <= 3'h0;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        CTRL_OFS: begin
          analog_loss_criterion <= w_data[CRIT_LSB +: 2] > CRIT_FULL ? CRIT_FULL : w_data[CRIT_LSB +: 2];
          loss_action_select <= w_data[ACTION_LSB +: 2] > ACT_DECEL ? ACT_DECEL : w_data[ACTION_LSB +: 2];
          brake_duty_limit_enable <= w_data[BRAKE_EN_BIT];
          charge_trip_enable <= w_data[CHARGE_EN_BIT];
          sum_mode <= w_data[SUM_MODE_BIT];
        end
        LOSS_TIME_OFS: begin
          loss_detect_time <= w_data[10:0] < LOSS_TIME_MIN ? LOSS_TIME_MIN
                            : (w_data[10:0] > LOSS_TIME_MAX ? LOSS_TIME_MAX : w_data[10:0]);
        end
        OUT_FUNC_OFS: begin
          relay_function_select <= w_data[4:0];
          output2_function_select <= w_data[OUT2_LSB +: 5];
        end
        BRAKE_DUTY_OFS: begin
          brake_duty_percent <= w_data[4:0] > DUTY_MAX ? DUTY_MAX : w_data[4:0];
        end
        BRAKE_CYCLE_OFS: begin
          brake_cycle_ticks <= w_data[15:0] == 16'h0000 ? 16'h0001 : w_data[15:0];
        end
        VOLT_TH_OFS: begin
          voltage_input_threshold <= w_data[11:0];
          second_voltage_threshold <= w_data[SECOND_TH_LSB +: 12];
        end
        CUR_TH_OFS: current_input_threshold <= w_data[11:0];
        IRQ_MASK_OFS: irq_mask <= w_data[2:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: begin
        rd_word[CRIT_LSB +: 2] = analog_loss_criterion;
        rd_word[ACTION_LSB +: 2] = loss_action_select;
        rd_word[BRAKE_EN_BIT] = brake_duty_limit_enable;
        rd_word[CHARGE_EN_BIT] = charge_trip_enable;
        rd_word[SUM_MODE_BIT] = sum_mode;
      end
      LOSS_TIME_OFS: rd_word[10:0] = loss_detect_time;
      OUT_FUNC_OFS: begin
        rd_word[4:0] = relay_function_select;
        rd_word[OUT2_LSB +: 5] = output2_function_select;
      end
      BRAKE_DUTY_OFS: rd_word[4:0] = brake_duty_percent;
      BRAKE_CYCLE_OFS: rd_word[15:0] = brake_cycle_ticks;
      VOLT_TH_OFS: begin
        rd_word[11:0] = voltage_input_threshold;
        rd_word[SECOND_TH_LSB +: 12] = second_voltage_threshold;
      end
      CUR_TH_OFS: rd_word[11:0] = current_input_threshold;
      STATUS_OFS: rd_word[5:0] = {charge_circuit_trip, cont_cutoff, budget_spent,
                                  brake_drive, candidate, loss_active};
      IRQ_STAT_OFS: rd_word[2:0] = irq_status;
      IRQ_MASK_OFS: rd_word[2:0] = irq_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : drive_protection_monitor

// ### analog_front.sv
// Purpose: far-side model of the analog speed command terminals
// Assumes: the bench sets the wanted levels
// Notes: a cut cable reads as zero, which is how a lost command looks
`timescale 1ns/1ns
module analog_front (
  // control
  input wire logic cut,
  input wire logic [11:0] v_set,
  input wire logic [11:0] s_set,
  input wire logic [11:0] c_set,
  // terminals
  output logic [11:0] v,
  output logic [11:0] s,
  output logic [11:0] c
);
  // broken wiring pulls every input to the bottom of its range
  assign v = cut ? 12'h000 : v_set;
  assign s = cut ? 12'h000 : s_set;
  assign c = cut ? 12'h000 : c_set;
endmodule : analog_front

// ### drive_prot_chk.sv
// Purpose: port-level checks of the protection monitor
// Assumes: single mclk domain
// Notes: attached by bind below
`timescale 1ns/1ns
module drive_prot_chk #(parameter int TICK_LEN = 10) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic brake_request,
  input wire logic powerup_phase,
  input wire logic power_unstable,
  input wire logic charge_circuit_fail,
  input wire logic hold_frequency,
  input wire logic output_block,
  input wire logic decel_stop,
  input wire logic relay_contact_output,
  input wire logic dynamic_braking,
  input wire logic charge_circuit_trip
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // length of the present braking run, in cycles
  int run;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) run <= 0;
    else run <= dynamic_braking ? run + 1 : 0;
  end
  a_trip_sticky: assert property (charge_circuit_trip |=> charge_circuit_trip)
    else $error("charge trip dropped");
  a_trip_blocks: assert property (charge_circuit_trip |=> output_block)
    else $error("trip without output block");
  a_trip_cause: assert property ($rose(charge_circuit_trip) |-> $past(powerup_phase) && ($past(power_unstable) || $past(charge_circuit_fail)))
    else $error("trip without cause");
  a_trip_nobrake: assert property (charge_circuit_trip [*3] |-> !dynamic_braking)
    else $error("braking during trip");
  a_brake_req: assert property (!brake_request |-> ##2 !dynamic_braking)
    else $error("braking without request");
  a_brake_cont: assert property (run <= 150 * TICK_LEN + 3)
    else $error("continuous braking too long");
  a_react_excl: assert property (!charge_circuit_trip |-> $onehot0({hold_frequency, output_block, decel_stop}))
    else $error("two reactions at once");
  a_relay_loss: assert property (relay_contact_output |-> (hold_frequency || output_block || decel_stop))
    else $error("relay without loss");
  c_hold: cover property ($rose(hold_frequency));
  c_trip: cover property ($rose(charge_circuit_trip));
  c_cut: cover property ($fell(dynamic_braking) && brake_request);
endmodule : drive_prot_chk
bind drive_protection_monitor drive_prot_chk #(.TICK_LEN(TICK_LEN)) u_chk (.*);

// ### tb_drive_protection_monitor.sv
// Purpose: self-checking bench of the protection monitor
// Assumes: TICK_LEN shortened to 10 cycles
// Notes: random loss cases from a fixed xorshift seed
`timescale 1ns/1ns
module tb_drive_protection_monitor;
  import drive_prot_pkg::*;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, x, seed = 32'hF0DE;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic brake_request = 1'h0, powerup_phase = 1'h0, power_unstable = 1'h0, charge_circuit_fail = 1'h0, cut = 1'h0;
  logic [11:0] vs = 12'hFFF, ss = 12'hFFF, cs = 12'hFFF;
  logic [11:0] voltage_command_input, second_voltage_input, current_command_input;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, l, ta, tw, tr;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, cr, act;
  logic hold_frequency, output_block, decel_stop, relay_contact_output, output2, dynamic_braking, charge_circuit_trip, irq;
  int miscompares = 0, total_checks = 0, k, i, n;
  logic [7:0] ra [8] = '{CTRL_OFS, LOSS_TIME_OFS, OUT_FUNC_OFS, BRAKE_DUTY_OFS, BRAKE_CYCLE_OFS, VOLT_TH_OFS, CUR_TH_OFS, IRQ_MASK_OFS};
  logic [31:0] rv [8] = '{32'h30, 32'hA, 32'h1111, 32'hA, 32'h64, 32'h1000100, 32'h100, 32'h0};
  always #10 mclk = ~mclk;
  analog_front far (.cut(cut), .v_set(vs), .s_set(ss), .c_set(cs), .v(voltage_command_input),
    .s(second_voltage_input), .c(current_command_input));
  drive_protection_monitor #(.TICK_LEN(10)) dut (.*);
  // ----
  // bench helpers
  // ----
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // thresholds as programmed below: 0x200, 0x300, 0x180
  function automatic logic lossf(input logic [1:0] c, input logic sm);
    logic [11:0] a, b, d;
    a = 12'h200 >> (c == 2'h1);
    b = 12'h300 >> (c == 2'h1);
    d = 12'h180 >> (c == 2'h1);
    return c != 2'h0 && (sm ? (second_voltage_input < b || current_command_input < d) : voltage_command_input < a);
  endfunction : lossf
  // handshakes are seen at the falling edge, acted on at the next rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_bready <= 1'h0;
      if (tr) break;
    end
    if (n == 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      if (tr) break;
    end
    if (n == 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : rdr
  task automatic settle(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic count(input int c);
    settle(3);
    k = 0;
    repeat (c) begin
      @(negedge mclk);
      k += int'(dynamic_braking === 1'h1);
    end
  endtask : count
  initial begin
    #1_000_000;
    miscompares++;
    tally_and_finish();
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    for (i = 0; i < 8; i++) begin
      rdr(ra[i]);
      chk("reset value", rd, rv[i]);
    end
    rdr(8'h28);
    chk("unmapped", {rsp, rd[29:0]}, 32'h80000000);
    wr(8'h28, 32'h0);
    chk("bad write", rsp, 2'h2);
    wr(VOLT_TH_OFS, 32'h03000200);
    wr(CUR_TH_OFS, 32'h180);
    wr(IRQ_MASK_OFS, 32'h7);
    wr(OUT_FUNC_OFS, 32'h110B);
    wr(CTRL_OFS, 32'h36);
    wr(LOSS_TIME_OFS, 32'h5);
    chk("write resp", rsp, 2'h0);
    @(posedge mclk);
    vs <= 12'h1FF;
    settle(35);
    chk("early", output_block, 1'h0);
    @(posedge mclk);
    vs <= 12'hFFF;
    repeat (2) @(posedge mclk);
    vs <= 12'h1FF;
    settle(35);
    chk("restart", output_block, 1'h0);
    settle(30);
    chk("loss", {output_block, relay_contact_output, output2, irq}, 4'hD);
    wr(IRQ_STAT_OFS, 32'h1);
    settle(2);
    chk("irq clear", irq, 1'h0);
    $display("test loss timing done");
    for (i = 0; i < 14; i++) begin
      x = xs();
      cr = 2'(x % 3);
      act = 2'((x >> 2) % 3);
      wr(CTRL_OFS, {25'h0, x[8], 2'h3, act, cr});
      wr(OUT_FUNC_OFS, {19'h0, x[9] ? 5'h0B : 5'h11, 3'h0, 5'h0B});
      wr(LOSS_TIME_OFS, 32'h2);
      @(posedge mclk);
      cut <= x[10] & x[11];
      vs <= 12'(xs() & 32'h3FF);
      ss <= 12'(xs() & 32'h3FF);
      cs <= 12'(xs() & 32'h3FF);
      settle(40);
      l = lossf(cr, x[8]);
      chk("react", {hold_frequency, output_block, decel_stop, relay_contact_output, output2},
        {l && act == 2'h0, l && act == 2'h1, l && act == 2'h2, l, l && x[9]});
      @(posedge mclk);
      cut <= 1'h0;
      {vs, ss, cs} <= {3{12'hFFF}};
    end
    $display("test random loss done");
    wr(CTRL_OFS, 32'h30);
    wr(BRAKE_CYCLE_OFS, 32'hA);
    wr(BRAKE_DUTY_OFS, 32'h1E);
    @(posedge mclk);
    brake_request <= 1'h1;
    count(200);
    chk("duty share", k inside {[40:80]}, 1'h1);
    wr(BRAKE_DUTY_OFS, 32'h0);
    count(100);
    chk("zero duty", k, 0);
    wr(CTRL_OFS, 32'h20);
    count(100);
    chk("no limit", k, 100);
    count(950);
    chk("long run", k, 950);
    count(150);
    chk("cutoff", dynamic_braking, 1'h0);
    $display("test braking done");
    wr(CTRL_OFS, 32'h0);
    @(posedge mclk);
    powerup_phase <= 1'h1;
    power_unstable <= 1'h1;
    settle(10);
    chk("trip off", charge_circuit_trip, 1'h0);
    wr(IRQ_MASK_OFS, 32'h0);
    wr(CTRL_OFS, 32'h20);
    settle(3);
    chk("trip", {charge_circuit_trip, output_block, irq}, 3'h6);
    wr(IRQ_MASK_OFS, 32'h4);
    settle(2);
    chk("irq mask", irq, 1'h1);
    rdr(STATUS_OFS);
    chk("status trip", rd[5], 1'h1);
    @(posedge mclk);
    sys_rst <= 1'h1;
    powerup_phase <= 1'h0;
    power_unstable <= 1'h0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    settle(2);
    chk("trip reset", charge_circuit_trip, 1'h0);
    // a failed charge path alone must trip as well
    @(posedge mclk);
    powerup_phase <= 1'h1;
    charge_circuit_fail <= 1'h1;
    settle(3);
    chk("fail trip", {charge_circuit_trip, output_block}, 2'h3);
    $display("test charge trip done");
    tally_and_finish();
  end
endmodule : tb_drive_protection_monitor
